//--- design/faq_top.sv
// Alarm qualification core of a fire alarm control unit
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "faq_cfg.svh"
// ------------------------------------------------------------
// Behaviour
// - A schedule input switches coincidence checking; off means direct alarm.
// - Zone-dependent zones alarm only with two zones of one group.
// - One zone of a group: cadence buzzer, zone coincidence message.
// - Zone coincidence clears on operator reset or 5 min after fire.
// - Unit-dependent points alarm only with two such points in a zone.
// - One unit-dependent point: cadence buzzer, point coincidence message.
// - Coincidence latch holds at least 5 min; panel reset clears it.
// - A second point or zone ends coincidence and raises fire.
// - One delay of 0-255 s applies to delayed points.
// - Delayed point alarms after the whole delay; restore restarts it.
// - Pending delay: cadence buzzer and delayed alarm message.
// - Delayed trigger output is active during the delay only.
// - Delayed terms per point, per zone and for the system.
// - Verification on a conventional input disables its delay.
// - Verified zone: detector reset 15 s, alarm on recurrence in 110 s.
// - Alert annunciation enabled by schedule or always; lamp shows it.
// - Alert annunciation alarm holds the routing output off.
// - Routing follows missed acknowledge or investigation time.
// - Foreign or manual call alarm during timers routes at once.
// - Alarm past the allowed zones or per-zone count ends annunciation; manual call only when alone.
// - Allowed zones one to four; option for several alarms per zone.
// - Acknowledge and reset inputs; status output shows annunciation.
// ------------------------------------------------------------
module faq_top
   import faq_pkg::*;
#(
   parameter int TENTH_CYC = `FAQ_TENTH_CYC
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [`FAQ_NPT-1:0] pt_fire,
   input wire logic [`FAQ_NPT-1:0] pt_unit_dep,
   input wire logic [`FAQ_NPT-1:0] pt_delayed,
   input wire logic [`FAQ_NPT-1:0] pt_aa,
   input wire logic [`FAQ_NPT-1:0] pt_mcp,
   input wire logic [`FAQ_NZ-1:0] zone_dep,
   input wire logic [4*`FAQ_NZ-1:0] zone_group,
   input wire logic [`FAQ_NZ-1:0] conv_verify,
   input wire logic coinc_sched,
   input wire logic aa_sched,
   input wire logic reset_front,
   input wire logic reset_remote,
   input wire logic aa_ack,
   input wire logic aa_reset,
   output logic full_alarm,
   output logic routing,
   output logic aa_active,
   output logic aa_lamp,
   output logic buzzer,
   output logic [`FAQ_NZ-1:0] det_reset,
   output logic [`FAQ_NZ-1:0] zone_coinc,
   output logic [`FAQ_NPT-1:0] point_coinc,
   output logic [`FAQ_NPT-1:0] delayed_point_term,
   output logic [`FAQ_NZ-1:0] delayed_zone_term,
   output logic delayed_any_term,
   output faq_msg_type msg_kind,
   output logic [2:0] msg_zone,
   output logic [1:0] msg_point
);

   // ------------------------------------------------------------
   // Helpers and shared signals
   // ------------------------------------------------------------
   function automatic logic [5:0] ones(input logic [31:0] v);
      logic [5:0] n;
      n = 6'h00;
      for (int k = 0; k < 32; k++) begin
         n = n + 6'(v[k]);
      end
      return n;
   endfunction

   logic [7:0] delay_s;
   logic [6:0] ack_s;
   logic [3:0] inv_min;
   logic [3:0] aacfg;
   logic [23:0] tcnt;
   logic [3:0] scnt;
   logic [5:0] cad;
   logic [`FAQ_NPT-1:0] pq, dp, ud_act, alm_pt, plat;
   logic [`FAQ_NZ-1:0] ud_pair, zone_raw, zone_act, zone_alarm, zlat;
   logic [`FAQ_NZ-1:0] grp_pair, ver_latch, ver_rst, dz, zone_multi;
   faq_aa_type aa_st, next_aa;
   logic [9:0] aa_cnt;
   faq_msg_type next_kind;
   logic [4:0] next_idx;

   // Assertions of every section share this clock and reset
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   wire coinc_en = coinc_sched;
   wire clr_req = reset_front || reset_remote;
   wire aa_en = aa_sched || aacfg[`FAQ_AA_ALWAYS_BIT];
   wire fire_any = |zone_alarm;
   wire [2:0] aa_maxz = {1'b0, aacfg[`FAQ_AA_MAXZ_MSB:0]} + 3'h1;

   // ------------------------------------------------------------
   // Time base: tenth tick, second tick, buzzer cadence
   // ------------------------------------------------------------
   wire tick_t = tcnt == 24'(TENTH_CYC - 1);
   wire tick_s = tick_t && scnt == 4'(`FAQ_SEC_TENTHS - 1);
   wire cad_end = cad == 6'(`FAQ_BUZZ_PER_T - 1);

   // Free-running dividers; cadence runs always so all sources share phase
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         tcnt <= 24'h000000;
         scnt <= 4'h0;
         cad <= 6'h00;
      end else begin
         tcnt <= tick_t ? 24'h000000 : tcnt + 24'h000001;
         if (tick_t) begin
            scnt <= tick_s ? 4'h0 : scnt + 4'h1;
            cad <= cad_end ? 6'h00 : cad + 6'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // Register port: configuration and status
   // ------------------------------------------------------------
   wire wr_dly = reg_wr && reg_addr == `FAQ_REG_DELAY;
   wire wr_ack = reg_wr && reg_addr == `FAQ_REG_ACK;
   wire wr_inv = reg_wr && reg_addr == `FAQ_REG_INV;
   wire wr_cfg = reg_wr && reg_addr == `FAQ_REG_AACFG;
   wire [7:0] status = {2'h0, aa_en, |plat || |zlat, delayed_any_term,
                        aa_active, routing, full_alarm};
   wire [7:0] rd_sel =
      reg_addr == `FAQ_REG_DELAY ? delay_s :
      reg_addr == `FAQ_REG_ACK ? {1'b0, ack_s} :
      reg_addr == `FAQ_REG_INV ? {4'h0, inv_min} :
      reg_addr == `FAQ_REG_AACFG ? {4'h0, aacfg} :
      reg_addr == `FAQ_REG_STATUS ? status : 8'h00;

   // Writes take effect at once; a timer in progress sees the new limit
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         delay_s <= `FAQ_DELAY_RST;
         ack_s <= `FAQ_ACK_RST;
         inv_min <= `FAQ_INV_RST;
         aacfg <= `FAQ_AACFG_RST;
         reg_rdata <= 8'h00;
      end else begin
         if (wr_dly) delay_s <= reg_wdata;
         if (wr_ack) ack_s <= reg_wdata[6:0];
         if (wr_inv) inv_min <= reg_wdata[3:0];
         if (wr_cfg) aacfg <= reg_wdata[3:0];
         reg_rdata <= reg_rd ? rd_sel : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Per point: delay timer, verification select, address latch
   // ------------------------------------------------------------
   for (genvar gi = 0; gi < `FAQ_NPT; gi++) begin : g_pt
      localparam int Z = gi / `FAQ_NP;
      localparam bit IS_CONV = (gi % `FAQ_NP) == `FAQ_NP - 1;
      logic [8:0] dcnt;
      logic [8:0] pcnt;
      logic lat;
      wire ver = IS_CONV && conv_verify[Z];
      wire use_dly = pt_delayed[gi] && !ver;
      wire dly_done = delay_s == 8'h00 || dcnt > {1'b0, delay_s};
      wire ud = pt_unit_dep[gi] && coinc_en;
      wire pset = ud && pq[gi] && !ud_pair[Z];
      wire pexp = pcnt == 9'(`FAQ_COINC_TICKS);
      wire pclr = clr_req || ud_pair[Z] || !coinc_en || pexp;

      assign pq[gi] = ver ? ver_latch[Z] :
                      pt_fire[gi] && (!use_dly || dly_done);
      assign dp[gi] = pt_fire[gi] && use_dly && !dly_done;
      assign ud_act[gi] = ud && (pq[gi] || lat);
      assign alm_pt[gi] = pq[gi] && zone_alarm[Z];
      assign plat[gi] = lat;

      // Delay restarts whenever the point leaves fire state
      always_ff @(posedge ref_clk) begin
         if (!rstn || !pt_fire[gi] || !use_dly) begin
            dcnt <= 9'h000;
         end else if (tick_s && dcnt != 9'h1FF) begin
            dcnt <= dcnt + 9'h001;
         end
      end

      // Latch time counts only while the point is out of fire; set wins
      always_ff @(posedge ref_clk) begin
         if (!rstn) begin
            lat <= 1'b0;
            pcnt <= 9'h000;
         end else begin
            lat <= pset || (lat && !pclr);
            if (!lat || pq[gi]) pcnt <= 9'h000;
            else if (tick_s && !pexp) pcnt <= pcnt + 9'h001;
         end
      end

      a_delay_wait:
         assert property ((dp[gi] && !ver) |-> !pq[gi])
         else $error("delayed point qualified before its delay");
      a_delay_term:
         assert property (dp[gi] |=> delayed_point_term[gi])
         else $error("delayed trigger output missing during delay");
   end

   // ------------------------------------------------------------
   // Per zone: address pair, zone latch, verification sequencer
   // ------------------------------------------------------------
   for (genvar gz = 0; gz < `FAQ_NZ; gz++) begin : g_zn
      localparam int B = gz * `FAQ_NP;
      logic [`FAQ_NZ-1:0] same;
      logic [8:0] zcnt;
      logic zl;
      faq_ver_type vst, next_v;
      logic [6:0] vcnt;
      wire [3:0] grp = zone_group[4*gz +: 4];
      wire zd = zone_dep[gz] && coinc_en;
      wire zexp = zcnt == 9'(`FAQ_COINC_TICKS);
      wire zset = zd && zone_raw[gz] && !grp_pair[gz];
      wire zclr = clr_req || grp_pair[gz] || !coinc_en || zexp;
      wire [`FAQ_NP-1:0] pq_z = pq[B +: `FAQ_NP];
      wire [`FAQ_NP-1:0] ud_z = pt_unit_dep[B +: `FAQ_NP];
      wire cf = pt_fire[B + `FAQ_NP - 1] && conv_verify[gz];

      for (genvar gw = 0; gw < `FAQ_NZ; gw++) begin : g_grp
         assign same[gw] = zone_dep[gw] && zone_act[gw] &&
                           zone_group[4*gw +: 4] == grp;
      end

      assign ud_pair[gz] = ones(32'(ud_act[B +: `FAQ_NP])) >= 6'h02;
      assign zone_raw[gz] = coinc_en ?
                            (|(pq_z & ~ud_z) || ud_pair[gz]) : |pq_z;
      assign zone_act[gz] = zone_raw[gz] || zl;
      assign grp_pair[gz] = ones(32'(same)) >= 6'h02;
      assign zone_alarm[gz] = zone_raw[gz] && (!zd || grp_pair[gz]);
      assign zlat[gz] = zl;
      assign dz[gz] = |dp[B +: `FAQ_NP];
      assign zone_multi[gz] = ones(32'(alm_pt[B +: `FAQ_NP])) >= 6'h02;
      assign ver_latch[gz] = vst == VER_LATCH;
      assign ver_rst[gz] = next_v == VER_RESET;

      // Zone latch behaves like the point latch, one level up
      always_ff @(posedge ref_clk) begin
         if (!rstn) begin
            zl <= 1'b0;
            zcnt <= 9'h000;
         end else begin
            zl <= zset || (zl && !zclr);
            if (!zl || zone_raw[gz]) zcnt <= 9'h000;
            else if (tick_s && !zexp) zcnt <= zcnt + 9'h001;
         end
      end

      // Verification: reset the detectors, then watch for recurrence
      always_comb begin
         next_v = vst;
         unique case (vst)
            VER_IDLE: if (cf) next_v = VER_RESET;
            VER_RESET: begin
               if (vcnt == 7'(`FAQ_VER_RESET_TICKS)) next_v = VER_WATCH;
            end
            VER_WATCH: begin
               if (cf) next_v = VER_LATCH;
               else if (vcnt == 7'(`FAQ_VER_WATCH_S)) next_v = VER_IDLE;
            end
            VER_LATCH: if (clr_req) next_v = VER_IDLE;
         endcase
         if (!conv_verify[gz]) next_v = VER_IDLE;
      end

      always_ff @(posedge ref_clk) begin
         if (!rstn) begin
            vst <= VER_IDLE;
            vcnt <= 7'h00;
         end else begin
            vst <= next_v;
            if (next_v != vst) vcnt <= 7'h00;
            else if (tick_s && vcnt != 7'h7F) vcnt <= vcnt + 7'h01;
         end
      end

      a_verify_reset:
         assert property ((vst == VER_IDLE && cf) |=>
                          vst == VER_RESET ##1 det_reset[gz])
         else $error("verified zone did not reset its detectors");
      a_zone_term:
         assert property (delayed_zone_term[gz] |-> delayed_any_term)
         else $error("zone delayed term without general term");
   end

   // ------------------------------------------------------------
   // Alert annunciation sequencer
   // ------------------------------------------------------------
   wire mcp_shared = |(alm_pt & pt_mcp) && ones(alm_pt) >= 6'h02;
   wire route_now = fire_any && (!aa_en
      || |(alm_pt & ~pt_aa & ~pt_mcp)
      || mcp_shared
      || ones(32'(zone_alarm)) > {3'h0, aa_maxz}
      || (!aacfg[`FAQ_AA_MULTI_BIT] && |zone_multi));
   wire aa_clr = clr_req || aa_reset;
   wire [9:0] inv_lim = 10'(inv_min) * 10'(`FAQ_SEC_PER_MIN);

   // Clear beats everything outside AA_IDLE; a foreign alarm beats acknowledge
   always_comb begin
      next_aa = aa_st;
      unique case (aa_st)
         AA_IDLE: begin
            if (fire_any) next_aa = route_now ? AA_ROUTED : AA_ACK;
         end
         AA_ACK: begin
            if (aa_clr) next_aa = AA_IDLE;
            else if (route_now) next_aa = AA_ROUTED;
            else if (aa_ack) next_aa = AA_INV;
            else if (aa_cnt > {3'h0, ack_s}) next_aa = AA_ROUTED;
         end
         AA_INV: begin
            if (aa_clr) next_aa = AA_IDLE;
            else if (route_now || aa_cnt > inv_lim) next_aa = AA_ROUTED;
         end
         AA_ROUTED: if (aa_clr) next_aa = AA_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         aa_st <= AA_IDLE;
         aa_cnt <= 10'h000;
      end else begin
         aa_st <= next_aa;
         if (next_aa != aa_st) aa_cnt <= 10'h000;
         else if (tick_s && aa_cnt != 10'h3FF) aa_cnt <= aa_cnt + 10'h001;
      end
   end

   // ------------------------------------------------------------
   // Display message: fire over coincidence over delayed, lowest index
   // ------------------------------------------------------------
   always_comb begin
      next_kind = MSG_NONE;
      next_idx = 5'h00;
      for (int k = `FAQ_NPT - 1; k >= 0; k--) begin
         if (dp[k]) begin
            next_kind = MSG_DELAYED;
            next_idx = 5'(k);
         end
      end
      for (int z = `FAQ_NZ - 1; z >= 0; z--) begin
         if (zlat[z]) begin
            next_kind = MSG_ZONE_COINC;
            next_idx = 5'(z * `FAQ_NP);
         end
      end
      for (int k = `FAQ_NPT - 1; k >= 0; k--) begin
         if (plat[k]) begin
            next_kind = MSG_POINT_COINC;
            next_idx = 5'(k);
         end
      end
      for (int k = `FAQ_NPT - 1; k >= 0; k--) begin
         if (alm_pt[k]) begin
            next_kind = MSG_FIRE;
            next_idx = 5'(k);
         end
      end
   end

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   wire pre_warn = |plat || |zlat || |dp;
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         full_alarm <= 1'b0;
         routing <= 1'b0;
         aa_active <= 1'b0;
         aa_lamp <= 1'b0;
         buzzer <= 1'b0;
         det_reset <= '0;
         zone_coinc <= '0;
         point_coinc <= '0;
         delayed_point_term <= '0;
         delayed_zone_term <= '0;
         delayed_any_term <= 1'b0;
         msg_kind <= MSG_NONE;
         msg_zone <= 3'h0;
         msg_point <= 2'h0;
      end else begin
         full_alarm <= fire_any;
         routing <= next_aa == AA_ROUTED;
         aa_active <= next_aa == AA_ACK || next_aa == AA_INV;
         aa_lamp <= aa_en;
         // Full alarm sounds steadily; pre-warnings use the cadence
         buzzer <= fire_any ||
                   (pre_warn && cad < 6'(`FAQ_BUZZ_ON_T));
         det_reset <= ver_rst;
         zone_coinc <= zlat;
         point_coinc <= plat;
         delayed_point_term <= dp;
         delayed_zone_term <= dz;
         delayed_any_term <= |dp;
         msg_kind <= next_kind;
         msg_zone <= next_idx[4:2];
         msg_point <= next_idx[1:0];
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_direct_fire:
      assert property ((!coinc_en && |pq) |=> full_alarm)
      else $error("fire not raised with coincidence off");
   a_buzz_cadence:
      assert property ((buzzer && !full_alarm) |->
                       $past(cad) < 6'(`FAQ_BUZZ_ON_T))
      else $error("buzzer on outside cadence window");
   a_lamp_enable:
      assert property ((aa_sched && !aa_clr) |=> aa_lamp)
      else $error("routing delay lamp dark while enabled");
   a_aa_holds:
      assert property ((aa_st == AA_IDLE && fire_any && !route_now)
                       |=> !routing && aa_st == AA_ACK)
      else $error("annunciation alarm routed directly");
   a_ack_timeout:
      assert property ((aa_st == AA_ACK && !aa_clr && !aa_ack &&
                        aa_cnt > {3'h0, ack_s}) |=> routing)
      else $error("routing missing after acknowledge time");
   a_foreign_route:
      assert property (((aa_st == AA_ACK || aa_st == AA_INV) &&
                        route_now && !aa_clr) |=> routing)
      else $error("foreign alarm did not route at once");

   c_ack_path: cover property (aa_st == AA_ACK ##1 aa_st == AA_INV);
   c_coinc_fire: cover property (|zlat ##1 full_alarm);
   c_delay_fire: cover property (delayed_any_term ##1 full_alarm);
   c_point_coinc: cover property ($rose(|point_coinc));

endmodule

//--- shared/faq_cfg.svh
// Constants of the fire alarm qualifier: sizes, offsets, fields, timing
`ifndef FAQ_CFG_SVH
`define FAQ_CFG_SVH
// ------------------------------------------------------------
// Sizes: zones, points per zone, points in total
// ------------------------------------------------------------
`define FAQ_NZ 8
`define FAQ_NP 4
`define FAQ_NPT 32
// ------------------------------------------------------------
// Register offsets, fields and reset values
// ------------------------------------------------------------
`define FAQ_REG_DELAY 4'h0
`define FAQ_REG_ACK 4'h1
`define FAQ_REG_INV 4'h2
`define FAQ_REG_AACFG 4'h3
`define FAQ_REG_STATUS 4'h4
`define FAQ_AA_MAXZ_MSB 1
`define FAQ_AA_MULTI_BIT 2
`define FAQ_AA_ALWAYS_BIT 3
`define FAQ_DELAY_RST 8'h00
`define FAQ_ACK_RST 7'h1E
`define FAQ_INV_RST 4'h2
`define FAQ_AACFG_RST 4'h0
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define FAQ_CLK_HZ 100000000
`define FAQ_TENTH_MS 100
`define FAQ_TENTH_CYC (`FAQ_CLK_HZ / 1000 * `FAQ_TENTH_MS)
`define FAQ_SEC_TENTHS 10
`define FAQ_SEC_PER_MIN 60
`define FAQ_BUZZ_ON_MS 800
`define FAQ_BUZZ_PER_MS 5000
`define FAQ_BUZZ_ON_T (`FAQ_BUZZ_ON_MS / `FAQ_TENTH_MS)
`define FAQ_BUZZ_PER_T (`FAQ_BUZZ_PER_MS / `FAQ_TENTH_MS)
`define FAQ_COINC_MIN 5
`define FAQ_COINC_TICKS (`FAQ_COINC_MIN * `FAQ_SEC_PER_MIN + 1)
`define FAQ_VER_RESET_S 15
`define FAQ_VER_RESET_TICKS (`FAQ_VER_RESET_S + 1)
`define FAQ_VER_WATCH_S 110
`endif

//--- shared/faq_pkg.sv
// Types of the fire alarm qualifier
package faq_pkg;
   typedef enum logic [1:0] {
      VER_IDLE, VER_RESET, VER_WATCH, VER_LATCH
   } faq_ver_type;
   typedef enum logic [1:0] {
      AA_IDLE, AA_ACK, AA_INV, AA_ROUTED
   } faq_aa_type;
   typedef enum logic [2:0] {
      MSG_NONE, MSG_DELAYED, MSG_ZONE_COINC, MSG_POINT_COINC, MSG_FIRE
   } faq_msg_type;
endpackage

//--- verification/faq_field.sv
// Far-side model: detectors, conventional zone inputs, operator buttons
`timescale 1ns/1ps
module faq_field (
   input wire logic ref_clk,
   input wire logic [31:0] smoke,
   input wire logic [7:0] det_reset,
   input wire logic [3:0] btn,
   output logic [31:0] pt_fire,
   output logic reset_front,
   output logic reset_remote,
   output logic aa_ack,
   output logic aa_reset
);
   logic [31:0] conv_off;
   // Cut power drops the conventional input; smoke still there recurs
   always_comb begin
      conv_off = '0;
      for (int z = 0; z < 8; z++) begin
         conv_off[4*z+3] = det_reset[z];
      end
   end
   // Field lines and buttons change just after the clock edge
   always_ff @(posedge ref_clk) begin
      pt_fire <= smoke & ~conv_off;
      {aa_reset, aa_ack, reset_remote, reset_front} <= btn;
   end
endmodule

//--- verification/tb.sv
// Self-checking bench of the fire alarm qualifier
`timescale 1ns/1ps
`include "faq_cfg.svh"
module tb
   import faq_pkg::*;
;
   localparam int SEC = 40; // 10 tenth ticks of 4 cycles
   logic ref_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
   logic coinc_sched = 0, aa_sched = 0;
   logic [3:0] reg_addr = '0, btn = '0;
   logic [7:0] reg_wdata = '0, reg_rdata, zone_dep = '0, conv_verify = '0;
   logic [7:0] det_reset, zone_coinc, delayed_zone_term;
   logic [31:0] smoke = '0, pt_unit_dep = '0, pt_delayed = '0, pt_aa = '0;
   logic [31:0] zone_group = '0, pt_fire, point_coinc, delayed_point_term;
   logic [31:0] pt_mcp = '0;
   logic [2:0] msg_zone;
   logic [1:0] msg_point;
   logic reset_front, reset_remote, aa_ack, aa_reset, full_alarm, routing;
   logic aa_active, aa_lamp, buzzer, delayed_any_term;
   faq_msg_type msg_kind;
   int fails = 0, samples_checked = 0, n;

   faq_top #(.TENTH_CYC(4)) dut (.ref_clk, .rstn, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .pt_fire, .pt_unit_dep, .pt_delayed,
      .pt_aa, .pt_mcp, .zone_dep, .zone_group, .conv_verify,
      .coinc_sched, .aa_sched, .reset_front, .reset_remote, .aa_ack,
      .aa_reset, .full_alarm, .routing, .aa_active, .aa_lamp, .buzzer,
      .det_reset, .zone_coinc, .point_coinc, .delayed_point_term,
      .delayed_zone_term, .delayed_any_term, .msg_kind, .msg_zone,
      .msg_point);
   faq_field field (.ref_clk, .smoke, .det_reset, .btn, .pt_fire,
      .reset_front, .reset_remote, .aa_ack, .aa_reset);

   // Clock of 10 ns
   always #5 ref_clk = ~ref_clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Waits k edges, then samples once the edge has settled
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   task automatic fire(input logic [31:0] s);
      @(posedge ref_clk);
      smoke <= s;
   endtask
   task automatic press(input logic [3:0] b);
      @(posedge ref_clk);
      btn <= b;
      @(posedge ref_clk);
      btn <= '0;
   endtask
   // Full restart keeps each scenario free of earlier latches
   task automatic rst();
      @(posedge ref_clk);
      rstn <= 1'b0;
      smoke <= '0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Watchdog: all scenarios need well under 40000 cycles
   initial begin
      #400000;
      fails++;
      give_verdict();
   end

   initial begin
      rst();
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h1E);
      rd(4'h2, 8'h02);
      rd(4'h3, 8'h00);
      rd(4'hF, 8'h00);
      wr(4'h0, 8'hFF);
      rd(4'h0, 8'hFF);
      // Plain point with annunciation off routes at once
      fire(32'h1);
      cyc(2);
      chk(full_alarm, 1'b1);
      chk(routing, 1'b1);
      chk(msg_kind, MSG_FIRE);
      rd(4'h4, 8'h03);
      // Zones 0 and 1 in group 1; schedule off bypasses coincidence
      rst();
      zone_dep <= 8'h03;
      zone_group <= 32'h11;
      fire(32'h1);
      cyc(2);
      chk(full_alarm, 1'b1);
      rst();
      coinc_sched <= 1'b1;
      fire(32'h1);
      cyc(4);
      chk(full_alarm, 1'b0);
      chk(zone_coinc, 8'h01);
      chk(msg_kind, MSG_ZONE_COINC);
      n = 0;
      repeat (1000) begin
         @(posedge ref_clk);
         n += buzzer;
      end
      chk(n, 160);
      fire(32'h11);
      cyc(3);
      chk(full_alarm, 1'b1);
      chk(zone_coinc, 8'h00);
      // Lone zone latch expires five minutes after fire leaves
      rst();
      fire(32'h1);
      cyc(SEC);
      fire(32'h0);
      cyc(290 * SEC);
      chk(zone_coinc, 8'h01);
      cyc(15 * SEC);
      chk(zone_coinc, 8'h00);
      // Points 16 and 17 of zone 4 depend on each other
      rst();
      pt_unit_dep <= 32'h30000;
      fire(32'h10000);
      cyc(4);
      chk(point_coinc, 32'h10000);
      chk(full_alarm, 1'b0);
      chk(msg_kind, MSG_POINT_COINC);
      fire(32'h0);
      press(4'h2);
      cyc(3);
      chk(point_coinc, 32'h0);
      fire(32'h10000);
      cyc(4);
      fire(32'h30000);
      cyc(3);
      chk(full_alarm, 1'b1);
      chk(point_coinc, 32'h0);
      // Delayed point 8 with a two second delay
      rst();
      coinc_sched <= 1'b0;
      pt_delayed <= 32'h108;
      wr(4'h0, 8'h02);
      fire(32'h100);
      cyc(3);
      chk(delayed_point_term, 32'h100);
      chk(delayed_zone_term, 8'h04);
      chk(delayed_any_term, 1'b1);
      chk(full_alarm, 1'b0);
      chk(msg_kind, MSG_DELAYED);
      chk(32'({msg_zone, msg_point}), 32'h08);
      fire(32'h0);
      cyc(3);
      chk(delayed_any_term, 1'b0);
      fire(32'h100);
      cyc(SEC + SEC / 2);
      chk(full_alarm, 1'b0);
      cyc(3 * SEC);
      chk(full_alarm, 1'b1);
      // Verified conventional input of zone 0, also marked delayed
      rst();
      conv_verify <= 8'h01;
      fire(32'h8);
      cyc(6);
      chk(full_alarm, 1'b0);
      chk(det_reset, 8'h01);
      chk(delayed_point_term, 32'h0);
      cyc(14 * SEC);
      chk(det_reset, 8'h01);
      cyc(4 * SEC);
      chk(det_reset, 8'h00);
      chk(full_alarm, 1'b1);
      chk(32'({msg_zone, msg_point}), 32'h03);
      // Annunciation: foreign alarm after acknowledge routes at once
      rst();
      pt_aa <= 32'h11;
      aa_sched <= 1'b1;
      fire(32'h1);
      cyc(3);
      chk(aa_lamp, 1'b1);
      chk(aa_active, 1'b1);
      chk(routing, 1'b0);
      press(4'h4);
      fire(32'h101);
      cyc(3);
      chk(routing, 1'b1);
      // Missed acknowledge of one second
      rst();
      wr(4'h1, 8'h01);
      fire(32'h1);
      cyc(3);
      chk(routing, 1'b0);
      cyc(4 * SEC);
      chk(routing, 1'b1);
      // Second zone beyond the allowed one
      rst();
      fire(32'h1);
      cyc(3);
      fire(32'h11);
      cyc(3);
      chk(routing, 1'b1);
      chk(aa_active, 1'b0);
      // Always-on annunciation with two zones allowed
      rst();
      aa_sched <= 1'b0;
      wr(4'h3, 8'h09);
      cyc(2);
      chk(aa_lamp, 1'b1);
      fire(32'h1);
      cyc(3);
      fire(32'h11);
      cyc(3);
      chk(routing, 1'b0);
      // Manual call alone starts annunciation; a second alarm routes
      rst();
      aa_sched <= 1'b1;
      pt_mcp <= 32'h100;
      pt_aa <= 32'h200;
      wr(4'h3, 8'h04);
      fire(32'h100);
      cyc(3);
      chk(aa_active, 1'b1);
      fire(32'h300);
      cyc(3);
      chk(routing, 1'b1);
      give_verdict();
   end
endmodule
